//--- hw/rx_error_pkg.sv
// Purpose: Constants for the receive error flag register block
// Assumes: Classic Wishbone slave, 32-bit data, byte addressed (0x18 flags, 0x1C control)
// Notes:   Register index 0x6 sits at byte address 0x18
package rx_error_pkg;

  localparam logic [7:0]  ERR_FLAGS_INDEX = 8'h06;
  localparam logic [7:0]  ERR_FLAGS_ADDR  = 8'h18;
  localparam logic [7:0]  CTRL_ADDR       = 8'h1C;
  localparam logic [31:0] ERR_FLAGS_RESET = 32'h00000000;
  localparam logic [31:0] UNMAPPED_READ   = 32'h00000000;
  localparam logic [1:0]  CRC_LEN_RESET   = 2'h2;
  localparam logic [12:0] MIN_LEN_RESET   = 13'h0000;
  localparam logic [12:0] MAX_LEN_RESET   = 13'h0FFF;
  localparam logic [6:0]  COLL_POS_RESET  = 7'h00;

  // Flag positions
  localparam int BIT_EMD_ANY        = 29;
  localparam int BIT_EMD_PHY        = 28;
  localparam int BIT_MINLEN         = 27;
  localparam int BIT_LE_CRC         = 26;
  localparam int BIT_SHORT_CHAR     = 25;
  localparam int BIT_NO_PARITY      = 24;
  localparam int BIT_NO_STOP        = 23;
  localparam int BIT_COLL_PARITY    = 22;
  localparam int BIT_COLL_STOP      = 21;
  localparam int BIT_COLLISION      = 18;
  localparam int BIT_HALT_RXOVER    = 17;
  localparam int BIT_HALT_FIELD     = 16;
  localparam int BIT_HALT_ERR       = 15;
  localparam int BIT_HALT_LEN       = 14;
  localparam int BIT_HALT_INVPAR    = 13;
  localparam int BIT_HALT_EOF       = 12;
  localparam int BIT_HALT_COLL      = 11;
  localparam int BIT_CRC            = 10;
  localparam int BIT_LEN_FIELD      = 9;
  localparam int BIT_PHY_COMM       = 8;
  localparam int BIT_PARITY         = 7;
  localparam int BIT_STOP           = 6;
  localparam int BIT_WRITE_ERR      = 5;
  localparam int BIT_POLL_OVFL      = 4;
  localparam int BIT_LATENCY        = 3;
  localparam int BIT_INTEGRITY      = 2;
  localparam int BIT_PROTOCOL       = 1;
  localparam int BIT_SUMMARY        = 0;

  localparam logic [7:0] POLL_PAYLOAD_LIMIT = 8'h1C;

  typedef enum logic [1:0] {
    MODE_A_106,
    MODE_A_HIGH,
    MODE_B,
    MODE_LEN_FIELD
  } rx_mode_type;

endpackage : rx_error_pkg

//--- hw/rx_error_flags.sv
// Purpose: Sticky receive error and stop cause flags, read over Wishbone
// Assumes: Event inputs are one-cycle pulses from logic on sys_clk
// Notes:   Read-only; a new reception clears all flags
//
// Behaviour
// RULE1: Bit 29 on disturbance anywhere; bit 28 on disturbance in physical layer.
// RULE2: Bit 27 when frame length breaks configured minimum.
// RULE3: Bit 26 when frame length is at most CRC field length.
// RULE4: Bit 25 when last character has fewer than eight bits.
// RULE5: Bit 24 when full last character lacks expected parity bit.
// RULE6: Bit 23 when full last character lacks expected stop bit.
// RULE7: Bit 22 on collision at parity bit; bit 21 at stop bit.
// RULE8: Bit 18 on any collision during reception.
// RULE9: Bit 17 when a receive-over message ends reception.
// RULE10: Bit 16 when external field loss interrupts reception.
// RULE11: Bit 15 when a communication error halts reception.
// RULE12: Bit 14 when byte counter ends length-field frame.
// RULE13: Bit 13 on inverted parity end in high-rate Type A.
// RULE14: Bit 12 on end-of-frame pattern in Type B modes.
// RULE15: Bit 11 on data collision end in 106 kbps Type A.
// RULE16: Bit 10 when CRC check fails.
// RULE17: Bit 9 on bad length field, length-field modes only.
// RULE18: Bit 8 when physical layer reports communication errors.
// RULE19: Bit 7 on parity error; bit 6 on zero stop bit.
// RULE20: Bit 5 on system write error ack; bit 3 on congestion.
// RULE21: Bit 4 when poll payload exceeds 28 bytes; the code sets it in length-field mode only.
// RULE22: Bit 2 integrity, bit 1 protocol, bit 0 either.
// RULE23: Collision position valid only while collision flag set; the code's valid output trails bit 18 by one cycle.
// RULE24: Flags read-only, reset zero, ignore writes, clear on new reception.
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps

module rx_error_flags
  import rx_error_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Receive path events, one-cycle pulses
  input  wire logic        rx_start,
  input  wire logic        disturbance_seen_phy,
  input  wire logic        disturbance_seen_decoder,
  input  wire logic        frame_end,
  input  wire logic [12:0] frame_bytes,
  input  wire logic [2:0]  last_char_bits,
  input  wire logic        last_parity_missing,
  input  wire logic        last_stop_missing,
  input  wire logic        coll_data,
  input  wire logic        coll_parity,
  input  wire logic        coll_stop,
  input  wire logic [6:0]  coll_pos_in,
  input  wire logic        halt_on_receive_over_msg,
  input  wire logic        halt_on_field_loss,
  input  wire logic        halt_on_comm_error,
  input  wire logic        halt_on_byte_count,
  input  wire logic        halt_on_inverted_parity,
  input  wire logic        halt_on_eof_pattern,
  input  wire logic        crc_fail,
  input  wire logic        len_short,
  input  wire logic [12:0] len_field,
  input  wire logic        phy_comm_error,
  input  wire logic        parity_fail,
  input  wire logic        stop_bit_sample,
  input  wire logic        stop_bit_strobe,
  input  wire logic        sys_write_err_ack,
  input  wire logic        sys_write_congested,
  input  wire logic        poll_request_active,
  input  wire logic [7:0]  poll_payload_len,
  // Status outputs
  output logic      [31:0] receive_error_flags,
  output logic      [6:0]  collision_position,
  output logic             collision_position_valid
);

  // Control register: [1:0] mode, [3:2] CRC field bytes, [7:4] read as zero,
  // [19:8] maximum length, [31:20] minimum length
  logic [1:0]  mode;
  logic [12:0] min_len;
  logic [12:0] max_len;
  logic [1:0]  crc_len;
  logic [6:0]  coll_pos_hold;
  logic        data_coll_seen;

  wire logic        bus_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic        hit_flags  = wb_adr_i == ERR_FLAGS_ADDR;
  wire logic        hit_ctrl   = wb_adr_i == CTRL_ADDR;
  wire logic        ctrl_write = bus_req && wb_we_i && hit_ctrl && wb_sel_i[0];
  wire logic        len_write  = bus_req && wb_we_i && hit_ctrl && (&wb_sel_i[3:1]);
  wire logic [31:0] ctrl_view  = {min_len[11:0], max_len[11:0], 4'h0, crc_len, mode};
  wire logic [31:0] read_mux   = hit_flags ? receive_error_flags :
                                 hit_ctrl  ? ctrl_view : UNMAPPED_READ;

  wire logic mode_len   = mode == MODE_LEN_FIELD;
  wire logic mode_a106  = mode == MODE_A_106;
  wire logic mode_ahigh = mode == MODE_A_HIGH;
  wire logic mode_b     = mode == MODE_B;

  // Per-bit set terms
  logic [31:0] set_vec;
  wire logic short_frame  = frame_end && (frame_bytes < min_len);                          // see RULE2
  wire logic le_crc       = frame_end && (frame_bytes <= {11'h000, crc_len});              // see RULE3
  wire logic short_char   = frame_end && (last_char_bits != 3'h0);                         // see RULE4
  wire logic full_no_par  = frame_end && (last_char_bits == 3'h0) && last_parity_missing;  // see RULE5
  wire logic full_no_stop = frame_end && (last_char_bits == 3'h0) && last_stop_missing;    // see RULE6
  wire logic len_bad      = mode_len && (len_short ||
                            (frame_end && (len_field < min_len || len_field > max_len)));  // see RULE17
  wire logic stop_zero    = stop_bit_strobe && !stop_bit_sample;                           // see RULE19
  wire logic poll_ovfl    = mode_len && poll_request_active
                            && (poll_payload_len > POLL_PAYLOAD_LIMIT);                    // see RULE21
  wire logic integrity    = parity_fail || crc_fail;                                       // see RULE22
  wire logic protocol     = stop_zero || full_no_par || short_char;                        // see RULE22

  always_comb begin
    set_vec                  = 32'h00000000;
    set_vec[BIT_EMD_ANY]     = disturbance_seen_phy || disturbance_seen_decoder;         // see RULE1
    set_vec[BIT_EMD_PHY]     = disturbance_seen_phy;                                     // see RULE1
    set_vec[BIT_MINLEN]      = short_frame;
    set_vec[BIT_LE_CRC]      = le_crc;
    set_vec[BIT_SHORT_CHAR]  = short_char;
    set_vec[BIT_NO_PARITY]   = full_no_par;
    set_vec[BIT_NO_STOP]     = full_no_stop;
    set_vec[BIT_COLL_PARITY] = coll_parity;                                              // see RULE7
    set_vec[BIT_COLL_STOP]   = coll_stop;                                                // see RULE7
    set_vec[BIT_COLLISION]   = coll_data || coll_parity || coll_stop;                    // see RULE8
    set_vec[BIT_HALT_RXOVER] = halt_on_receive_over_msg;                                 // see RULE9
    set_vec[BIT_HALT_FIELD]  = halt_on_field_loss;                                       // see RULE10
    set_vec[BIT_HALT_ERR]    = halt_on_comm_error;                                       // see RULE11
    set_vec[BIT_HALT_LEN]    = halt_on_byte_count && mode_len;                           // see RULE12
    set_vec[BIT_HALT_INVPAR] = halt_on_inverted_parity && mode_ahigh;                    // see RULE13
    set_vec[BIT_HALT_EOF]    = halt_on_eof_pattern && mode_b;                            // see RULE14
    set_vec[BIT_HALT_COLL]   = coll_data && mode_a106;                                   // see RULE15
    set_vec[BIT_CRC]         = crc_fail;                                                 // see RULE16
    set_vec[BIT_LEN_FIELD]   = len_bad;
    set_vec[BIT_PHY_COMM]    = phy_comm_error;                                           // see RULE18
    set_vec[BIT_PARITY]      = parity_fail;                                              // see RULE19
    set_vec[BIT_STOP]        = stop_zero;
    set_vec[BIT_WRITE_ERR]   = sys_write_err_ack;                                        // see RULE20
    set_vec[BIT_POLL_OVFL]   = poll_ovfl;
    set_vec[BIT_LATENCY]     = sys_write_congested;                                      // see RULE20
    set_vec[BIT_INTEGRITY]   = integrity;
    set_vec[BIT_PROTOCOL]    = protocol;
    set_vec[BIT_SUMMARY]     = integrity || protocol;                                    // see RULE22
  end

  // Set beats the start-of-reception clear so a same-cycle event survives
  wire logic [31:0] next_flags = (rx_start ? 32'h00000000 : receive_error_flags) | set_vec; // see RULE24

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      receive_error_flags <= ERR_FLAGS_RESET;                                            // see RULE24
    end else begin
      receive_error_flags <= next_flags;
    end
  end

  // First data collision since start; parity or stop hits set bit 18 but must not block capture
  wire logic first_coll = coll_data && (!data_coll_seen || rx_start);                      // see RULE23

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      data_coll_seen <= 1'b0;
      coll_pos_hold  <= COLL_POS_RESET;
    end else begin
      data_coll_seen <= (data_coll_seen && !rx_start) || coll_data;
      if (first_coll) begin
        coll_pos_hold <= coll_pos_in;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      collision_position       <= COLL_POS_RESET;
      collision_position_valid <= 1'b0;
    end else begin
      collision_position       <= coll_pos_hold;
      collision_position_valid <= receive_error_flags[BIT_COLLISION];                    // see RULE23
    end
  end

  // Control register; writes to the flag word are acked and dropped
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mode    <= MODE_A_106;
      crc_len <= CRC_LEN_RESET;
      min_len <= MIN_LEN_RESET;
      max_len <= MAX_LEN_RESET;
    end else begin
      if (ctrl_write) begin
        mode    <= wb_dat_i[1:0];
        crc_len <= wb_dat_i[3:2];
      end
      if (len_write) begin
        max_len <= {1'b0, wb_dat_i[19:8]};
        min_len <= {1'b0, wb_dat_i[31:20]};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? read_mux : 32'h00000000;
    end
  end

endmodule : rx_error_flags

//--- bench/rx_error_flags_assertions.sv
// Purpose: Temporal checks on the receive error flag block
// Assumes: One clock, synchronous active-high reset
// Notes:   Sees only top-level ports
`timescale 1ns/1ps
module rx_error_flags_assertions (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        rx_start,
  input wire logic        crc_fail,
  input wire logic        parity_fail,
  input wire logic        stop_bit_strobe,
  input wire logic        stop_bit_sample,
  input wire logic        coll_data,
  input wire logic        coll_parity,
  input wire logic        coll_stop,
  input wire logic [31:0] receive_error_flags,
  input wire logic        collision_position_valid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_coll_valid; 1'b1 |=> collision_position_valid == $past(receive_error_flags[18]); endproperty
  property p_summary; receive_error_flags[0] == (receive_error_flags[1] || receive_error_flags[2]); endproperty
  property p_emd; receive_error_flags[28] |-> receive_error_flags[29]; endproperty
  property p_crc; crc_fail |=> receive_error_flags[10] && receive_error_flags[2]; endproperty
  property p_stop; stop_bit_strobe && !stop_bit_sample |=> receive_error_flags[6] && receive_error_flags[1]; endproperty
  property p_coll; coll_data || coll_parity || coll_stop |=> receive_error_flags[18]; endproperty
  property p_sticky; receive_error_flags[7] && !rx_start |=> receive_error_flags[7]; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("ack missing");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  a_coll_valid: assert property (p_coll_valid) else $error("position valid wrong");
  a_summary: assert property (p_summary) else $error("summary bit wrong");
  a_emd: assert property (p_emd) else $error("disturbance bits wrong");
  a_crc: assert property (p_crc) else $error("crc flag missing");
  a_stop: assert property (p_stop) else $error("stop flag missing");
  a_coll: assert property (p_coll) else $error("collision flag missing");
  a_sticky: assert property (p_sticky) else $error("parity flag lost");
  c_read: cover property (wb_ack_o);
  c_clear: cover property (rx_start ##1 receive_error_flags == 32'h0);
  c_coll: cover property (collision_position_valid);
endmodule : rx_error_flags_assertions

bind rx_error_flags rx_error_flags_assertions rx_error_flags_assertions_inst (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .rx_start(rx_start), .crc_fail(crc_fail), .parity_fail(parity_fail), .stop_bit_strobe(stop_bit_strobe),
  .stop_bit_sample(stop_bit_sample), .coll_data(coll_data), .coll_parity(coll_parity), .coll_stop(coll_stop),
  .receive_error_flags(receive_error_flags), .collision_position_valid(collision_position_valid));

//--- bench/rx_event_source.sv
// Purpose: Receive path event source on the decoder side
// Assumes: Bench holds go for one cycle per event
// Notes:   Stop sample idles high like a released line
`timescale 1ns/1ps
module rx_event_source (
  input  wire logic        go,
  input  wire logic [3:0]  pick,
  output logic      [15:0] ev,
  output logic             stop_bit_sample
);
  assign ev = go ? (16'h0001 << pick) : 16'h0000;
  // Low only under a stop strobe, so the strobe reads as a bad stop bit
  assign stop_bit_sample = !ev[10];
endmodule : rx_event_source

//--- bench/testbench.sv
// Purpose: Self-checking bench for the receive error flag block
// Assumes: Ack one cycle after request; flags land one edge after a pulse
// Notes:   Accumulated flag model compared after every event and read
`timescale 1ns/1ps
module testbench;
  import rx_error_pkg::*;
  logic        sys_clk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, go = 0, ack, cvalid, sample;
  logic        rx_start = 0, frame_end = 0, par_miss = 0, stop_miss = 0, coll_data = 0, poll_act = 0, lshort = 0;
  logic [3:0]  sel = 4'h0, pick = 4'h0;
  logic [7:0]  adr = 8'h00, poll_len = 8'h00;
  logic [12:0] fbytes = 13'h0000, lfield = 13'h0000;
  logic [2:0]  lbits = 3'h0;
  logic [6:0]  cpos = 7'h00, cposition;
  logic [15:0] ev;
  logic [31:0] wdat = 32'h0, dat, rdat, flags, exp_flags;
  int          n_mismatch = 0, total_checks = 0, cycles = 0, seed = 32'h9622, i;
  logic [31:0] mask [16] = '{32'h30000000, 32'h20000000, 32'h00440000, 32'h00240000, 32'h00020000,
    32'h00010000, 32'h00008000, 32'h00000405, 32'h00000100, 32'h00000085, 32'h00000043, 32'h00000020,
    32'h00000008, 32'h0, 32'h0, 32'h0};
  logic [31:0] fexp [4] = '{32'h04000000, 32'h02000003, 32'h01000003, 32'h00800000};
  logic [31:0] hmask [4] = '{32'h0, 32'h2000, 32'h1000, 32'h4000};
  int          hot [4] = '{0, 15, 13, 14};

  rx_error_flags rx_error_flags_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack),
    .rx_start(rx_start), .disturbance_seen_phy(ev[0]), .disturbance_seen_decoder(ev[1]), .frame_end(frame_end),
    .frame_bytes(fbytes), .last_char_bits(lbits), .last_parity_missing(par_miss), .last_stop_missing(stop_miss),
    .coll_data(coll_data), .coll_parity(ev[2]), .coll_stop(ev[3]), .coll_pos_in(cpos),
    .halt_on_receive_over_msg(ev[4]), .halt_on_field_loss(ev[5]), .halt_on_comm_error(ev[6]),
    .halt_on_byte_count(ev[14]), .halt_on_inverted_parity(ev[15]), .halt_on_eof_pattern(ev[13]),
    .crc_fail(ev[7]), .len_short(lshort), .len_field(lfield), .phy_comm_error(ev[8]), .parity_fail(ev[9]),
    .stop_bit_sample(sample), .stop_bit_strobe(ev[10]), .sys_write_err_ack(ev[11]),
    .sys_write_congested(ev[12]), .poll_request_active(poll_act), .poll_payload_len(poll_len),
    .receive_error_flags(flags), .collision_position(cposition), .collision_position_valid(cvalid));
  rx_event_source rx_event_source_inst (.go(go), .pick(pick), .ev(ev), .stop_bit_sample(sample));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] expv, input logic [31:0] got);
    total_checks++;
    if (got !== expv) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, expv, got);
    end
  endtask : check

  // Request held until ack is sampled; ack expected at the second edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Upper data in use means the length limits are meant too
    sel <= (d[31:8] == 24'h000000) ? 4'h1 : 4'hF;
    do begin
      @(posedge sys_clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    rdat = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    // Taken at the first edge, ack sampled at the second
    check("ack latency", 32'h2, k);
  endtask : wb

  task automatic pulse(input int idx, input logic [31:0] m);
    @(posedge sys_clk);
    go <= 1'b1;
    pick <= idx[3:0];
    @(posedge sys_clk);
    go <= 1'b0;
    @(negedge sys_clk);
    exp_flags = exp_flags | m;
    check("flags", exp_flags, flags);
  endtask : pulse

  task automatic clear();
    @(posedge sys_clk);
    rx_start <= 1'b1;
    @(posedge sys_clk);
    rx_start <= 1'b0;
    @(negedge sys_clk);
    exp_flags = 32'h0;
    check("flags after start", exp_flags, flags);
  endtask : clear

  initial begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk);
    exp_flags = 32'h0;
    check("reset flags", 32'h0, flags);
    for (int r = 0; r < 32; r++) begin
      i = (r < 16) ? r : {$random(seed)} % 16;
      pulse(i, mask[i]);
    end
    wb(1'b1, ERR_FLAGS_ADDR, 32'hFFFFFFFF);
    wb(1'b0, ERR_FLAGS_ADDR, 32'h0);
    check("read flags", exp_flags, rdat);
    wb(1'b0, 8'h40, 32'h0);
    check("unmapped read", 32'h0, rdat);
    for (int k = 0; k < 4; k++) begin
      clear();
      @(posedge sys_clk);
      frame_end <= 1'b1;
      fbytes <= (k == 0) ? 13'h0002 : 13'h000A;
      lbits <= (k == 1) ? 3'h3 : 3'h0;
      par_miss <= (k == 2);
      stop_miss <= (k == 3);
      @(posedge sys_clk);
      frame_end <= 1'b0;
      par_miss <= 1'b0;
      stop_miss <= 1'b0;
      @(negedge sys_clk);
      check("frame flags", fexp[k], flags);
    end
    clear();
    pulse(2, mask[2]);
    @(posedge sys_clk);
    coll_data <= 1'b1;
    cpos <= 7'h2A;
    @(posedge sys_clk);
    cpos <= 7'h05;
    @(posedge sys_clk);
    coll_data <= 1'b0;
    @(negedge sys_clk);
    check("collision position", 32'h2A, {25'h0, cposition});
    check("collision flag", 32'h00440800, flags);
    check("collision valid", 32'h1, {31'h0, cvalid});
    for (int m = 1; m < 4; m++) begin
      wb(1'b1, CTRL_ADDR, {28'h0, 2'h2, m[1:0]});
      clear();
      for (int j = 13; j < 16; j++) pulse(j, (j == hot[m]) ? hmask[m] : 32'h0);
    end
    @(posedge sys_clk);
    poll_act <= 1'b1;
    poll_len <= 8'h1C;
    repeat (2) @(posedge sys_clk);
    poll_len <= 8'h1D;
    @(negedge sys_clk);
    check("poll at limit", exp_flags, flags);
    @(negedge sys_clk);
    check("poll over limit", exp_flags | 32'h10, flags);
    @(posedge sys_clk);
    poll_act <= 1'b0;
    sys_rst <= 1'b1;
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk);
    check("flags after reset", 32'h0, flags);
    check("valid after reset", 32'h0, {31'h0, cvalid});
    // Min 8, max 16, CRC 2 bytes, length-field mode
    wb(1'b1, CTRL_ADDR, {12'h008, 12'h010, 8'h0B});
    clear();
    @(posedge sys_clk);
    frame_end <= 1'b1;
    fbytes <= 13'h0004;
    lfield <= 13'h0020;
    @(posedge sys_clk);
    frame_end <= 1'b0;
    @(negedge sys_clk);
    check("length flags", 32'h08000200, flags);
    clear();
    @(posedge sys_clk);
    lshort <= 1'b1;
    @(posedge sys_clk);
    lshort <= 1'b0;
    @(negedge sys_clk);
    check("short length", 32'h00000200, flags);
    print_verdict();
  end
endmodule : testbench
